/* File: verilog/rdsu_pkg.sv */
// package for the rotate and digit shift unit
// shared by the unit and its bench; no other dependencies
package rdsu_pkg;

    // instruction function codes, three decimal digits
    localparam logic [11:0] FUNC_ROT = 12'h028;
    localparam logic [11:0] FUNC_DSL = 12'h074;
    localparam logic [11:0] FUNC_DSR = 12'h075;

    // datapath geometry
    localparam int WORD_W = 16;
    localparam int ADDR_W = 16;
    localparam int NIB_W  = 4;

    // register byte offsets on the bus
    localparam logic [7:0] OFF_FLAGS    = 8'h00;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h04;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h08;

    // flag bit positions in the flags register
    localparam int FLG_NEG  = 0;
    localparam int FLG_CY   = 1;
    localparam int FLG_ZERO = 2;
    localparam int FLG_ERR  = 3;

    // interrupt bit positions
    localparam int IRQ_W    = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR  = 1;

    // reset values
    localparam logic [1:0]  IRQ_RST  = 2'h0;
    localparam logic [31:0] RD_RST   = 32'h0000_0000;
    localparam logic [7:0]  ADDR_RST = 8'h00;

    typedef struct packed
    {
        logic error_flag;
        logic zero_result_flag;
        logic carry_flag;
        logic negative_flag;
    } rdsu_flags_t;

    localparam rdsu_flags_t FLAGS_RST = 4'h0;

    typedef struct packed
    {
        logic              en;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } rdsu_wr_t;

    typedef enum logic [3:0]
    {
        SEQ_IDLE  = 4'h1,
        SEQ_ROT   = 4'h2,
        SEQ_LOAD  = 4'h4,
        SEQ_SHIFT = 4'h8
    } rdsu_state_t;

endpackage

/* File: verilog/rdsu_unit.sv */
// rotate right through carry and one digit range shifts, with flags
// assumes a word memory with a combinational read port and a write port
//
// Notes on behaviour
// RULE1: code 028 rotates one word operand
// RULE2: rotate: bits move down, carry loops round
// RULE3: rotate sets zero flag on zero result
// RULE4: rotate carry takes old bit zero
// RULE5: rotate negative flag follows result bit 15
// RULE6: codes 074/075 shift digits over range
// RULE7: left shift: zero low nibble, top lost
// RULE8: right shift: zero top nibble, low lost
// RULE9: error flag when start above end
// RULE10: issuer keeps range inside one area
// RULE11: error leaves memory untouched, one cycle
// RULE12: one word per clock from discarding end
`timescale 1ns/1ps

module rdsu_unit
(
    input  wire logic                       i_clk,
    input  wire logic                       i_rst_b,
    // instruction sequencer
    input  wire logic                       i_start,
    input  wire logic [11:0]                i_func,
    input  wire logic [rdsu_pkg::ADDR_W-1:0] i_addr_first,
    input  wire logic [rdsu_pkg::ADDR_W-1:0] i_addr_last,
    output logic                            o_busy,
    output logic                            o_done,
    // word memory
    output logic [rdsu_pkg::ADDR_W-1:0]     o_rd_addr,
    input  wire logic [rdsu_pkg::WORD_W-1:0] i_rd_data,
    output rdsu_pkg::rdsu_wr_t              o_wr,
    // flags
    output rdsu_pkg::rdsu_flags_t           o_flags,
    output logic                            o_irq,
    // ahb-lite slave
    input  wire logic                       i_hsel,
    input  wire logic [31:0]                i_haddr,
    input  wire logic [1:0]                 i_htrans,
    input  wire logic                       i_hwrite,
    input  wire logic [2:0]                 i_hsize,
    input  wire logic                       i_hready,
    input  wire logic [31:0]                i_hwdata,
    output logic [31:0]                     o_hrdata,
    output logic                            o_hreadyout,
    output logic                            o_hresp
);

    localparam int W = rdsu_pkg::WORD_W;
    localparam int A = rdsu_pkg::ADDR_W;
    localparam int N = rdsu_pkg::NIB_W;

    rdsu_pkg::rdsu_state_t  state_q;
    rdsu_pkg::rdsu_state_t  state_d;
    rdsu_pkg::rdsu_flags_t  flags_q;
    rdsu_pkg::rdsu_flags_t  flags_d;
    logic                   left_q;
    logic [A-1:0]           ptr_q;
    logic [A-1:0]           first_q;
    logic [A-1:0]           last_q;
    logic [W-1:0]           hold_q;
    logic                   done_q;
    logic [rdsu_pkg::IRQ_W-1:0] stat_q;
    logic [rdsu_pkg::IRQ_W-1:0] mask_q;
    logic                   bwr_q;
    logic [7:0]             baddr_q;
    logic [31:0]            hrdata_q;

    // instruction decode
    wire is_idle   = (state_q == rdsu_pkg::SEQ_IDLE);
    wire go        = i_start && is_idle;
    wire dec_rot   = (i_func == rdsu_pkg::FUNC_ROT);      // RULE1
    wire dec_dsl   = (i_func == rdsu_pkg::FUNC_DSL);      // RULE6
    wire dec_dsr   = (i_func == rdsu_pkg::FUNC_DSR);      // RULE6
    wire dec_dig   = dec_dsl || dec_dsr;
    wire range_bad = (i_addr_first > i_addr_last);        // RULE9
    wire go_rot    = go && dec_rot;
    wire go_dig    = go && dec_dig;
    wire go_err    = go_dig && range_bad;                 // RULE11
    wire go_shift  = go_dig && !range_bad;

    // shift walk
    wire in_shift  = (state_q == rdsu_pkg::SEQ_SHIFT);
    wire in_rot    = (state_q == rdsu_pkg::SEQ_ROT);
    wire in_load   = (state_q == rdsu_pkg::SEQ_LOAD);
    wire at_end    = left_q ? (ptr_q == first_q) : (ptr_q == last_q);
    wire [A-1:0] ptr_next = left_q ? A'(ptr_q - 1'b1) : A'(ptr_q + 1'b1);
    wire [N-1:0] in_nib = at_end ? 4'h0 :
                          (left_q ? i_rd_data[W-1 -: N] : i_rd_data[N-1:0]);
    wire [W-1:0] dig_word = left_q ?
                            {hold_q[W-N-1:0], in_nib} :   // RULE7
                            {in_nib, hold_q[W-1:N]};      // RULE8
    wire [W-1:0] rot_word = {flags_q.carry_flag, i_rd_data[W-1:1]}; // RULE2

    // memory ports
    assign o_rd_addr = in_shift ? ptr_next : ptr_q;
    assign o_wr.en   = in_rot || in_shift;
    assign o_wr.addr = ptr_q;
    assign o_wr.data = in_rot ? rot_word : dig_word;

    // sequencer
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            rdsu_pkg::SEQ_IDLE:
            begin
                if (go_rot)
                    state_d = rdsu_pkg::SEQ_ROT;
                else if (go_shift)
                    state_d = rdsu_pkg::SEQ_LOAD;    // RULE12
            end
            rdsu_pkg::SEQ_ROT:
                state_d = rdsu_pkg::SEQ_IDLE;
            rdsu_pkg::SEQ_LOAD:
                state_d = rdsu_pkg::SEQ_SHIFT;
            rdsu_pkg::SEQ_SHIFT:
            begin
                if (at_end)
                    state_d = rdsu_pkg::SEQ_IDLE;
            end
        endcase
    end

    wire finish = in_rot || (in_shift && at_end) || go_err;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_q <= rdsu_pkg::SEQ_IDLE;
            done_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            done_q  <= finish;
        end
    end

    // operand latch, start from the discarding end
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            left_q  <= 1'b0;
            first_q <= '0;
            last_q  <= '0;
            ptr_q   <= '0;
        end
        else if (go)
        begin
            left_q  <= dec_dsl;
            first_q <= i_addr_first;
            last_q  <= i_addr_last;
            ptr_q   <= dec_dsl ? i_addr_last : i_addr_first; // RULE12
        end
        else if (in_shift && !at_end)
            ptr_q   <= ptr_next;                             // RULE12
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            hold_q <= '0;
        else if (in_load || in_shift)
            hold_q <= i_rd_data;
    end

    // flags
    always_comb
    begin
        flags_d = flags_q;
        if (bwr_q && (baddr_q == rdsu_pkg::OFF_FLAGS))
            flags_d.carry_flag = i_hwdata[rdsu_pkg::FLG_CY];
        if (go_dig)
            flags_d.error_flag = range_bad;                  // RULE9
        if (in_rot)
        begin
            flags_d.error_flag       = 1'b0;
            flags_d.carry_flag       = i_rd_data[0];         // RULE4
            flags_d.zero_result_flag = (rot_word == '0);     // RULE3
            flags_d.negative_flag    = rot_word[W-1];        // RULE5
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            flags_q <= rdsu_pkg::FLAGS_RST;
        else
            flags_q <= flags_d;
    end

    assign o_flags = flags_q;
    assign o_busy  = !is_idle;
    assign o_done  = done_q;

    // interrupts, set wins over write-one-clear
    wire [rdsu_pkg::IRQ_W-1:0] ev = {go_err, finish};
    wire stat_wr = bwr_q && (baddr_q == rdsu_pkg::OFF_IRQ_STAT);
    wire mask_wr = bwr_q && (baddr_q == rdsu_pkg::OFF_IRQ_MASK);
    wire [rdsu_pkg::IRQ_W-1:0] clr = stat_wr ?
                                     i_hwdata[rdsu_pkg::IRQ_W-1:0] : 2'h0;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            stat_q <= rdsu_pkg::IRQ_RST;
            mask_q <= rdsu_pkg::IRQ_RST;
        end
        else
        begin
            stat_q <= (stat_q & ~clr) | ev;
            if (mask_wr)
                mask_q <= i_hwdata[rdsu_pkg::IRQ_W-1:0];
        end
    end

    assign o_irq = |(stat_q & mask_q);

    // bus slave, zero wait states
    wire addr_ph = i_hsel && i_htrans[1] && i_hready;
    wire [7:0] a_off = i_haddr[7:0];
    wire [31:0] rd_mux =
        (a_off == rdsu_pkg::OFF_FLAGS)    ? {28'h0, flags_q} :
        (a_off == rdsu_pkg::OFF_IRQ_STAT) ? {30'h0, stat_q}  :
        (a_off == rdsu_pkg::OFF_IRQ_MASK) ? {30'h0, mask_q}  :
                                            32'h0000_0000;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            bwr_q    <= 1'b0;
            baddr_q  <= rdsu_pkg::ADDR_RST;
            hrdata_q <= rdsu_pkg::RD_RST;
        end
        else
        begin
            bwr_q    <= addr_ph && i_hwrite;
            baddr_q  <= addr_ph ? a_off : baddr_q;
            hrdata_q <= (addr_ph && !i_hwrite) ? rd_mux : hrdata_q;
        end
    end

    assign o_hrdata    = hrdata_q;
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;

    // checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    sequence s_rot_issue;
        go && dec_rot;
    endsequence

    sequence s_rot_exec;
        ##1 in_rot && o_wr.en && (o_wr.addr == $past(i_addr_first));
    endsequence

    sequence s_good_range;
        go && dec_dig && !range_bad;
    endsequence

    sequence s_load_last;
        in_load && (o_rd_addr == $past(i_addr_last));
    endsequence

    sequence s_load_first;
        in_load && (o_rd_addr == $past(i_addr_first));
    endsequence

    a_rot_select: assert property (s_rot_issue |-> s_rot_exec)          // RULE1
        else $error("rotate not executed on its operand");

    a_rot_word: assert property (in_rot |->                     // RULE2
        o_wr.data == {flags_q.carry_flag, i_rd_data[W-1:1]})
        else $error("rotate result word wrong");

    a_rot_zero: assert property (in_rot ##1 1'b1 |->            // RULE3
        o_flags.zero_result_flag == ($past(o_wr.data) == 16'h0000))
        else $error("zero flag wrong after rotate");

    a_rot_carry: assert property (in_rot |=>                    // RULE4
        o_flags.carry_flag == $past(i_rd_data[0]))
        else $error("carry flag wrong after rotate");

    a_rot_neg: assert property (in_rot |=>                      // RULE5
        o_flags.negative_flag == $past(flags_q.carry_flag)
        && !o_flags.error_flag)
        else $error("negative flag wrong after rotate");

    a_dig_start: assert property (s_good_range |=>              // RULE6
        in_load ##1 in_shift)
        else $error("digit shift did not start");

    a_dsl_edge: assert property (in_shift && left_q && at_end |-> // RULE7
        o_wr.data[N-1:0] == 4'h0 &&
        o_wr.data[W-1:N] == hold_q[W-N-1:0])
        else $error("left digit shift edge word wrong");

    a_dsr_edge: assert property (in_shift && !left_q && at_end |-> // RULE8
        o_wr.data[W-1 -: N] == 4'h0 &&
        o_wr.data[W-N-1:0] == hold_q[W-1:N])
        else $error("right digit shift edge word wrong");

    a_err_flag: assert property (go && dec_dig |=>              // RULE9
        o_flags.error_flag == $past(range_bad))
        else $error("error flag does not follow range check");

    a_dig_flags: assert property (go_dig && !bwr_q |=>          // RULE9
        o_flags.zero_result_flag == $past(flags_q.zero_result_flag) &&
        o_flags.carry_flag == $past(flags_q.carry_flag) &&
        o_flags.negative_flag == $past(flags_q.negative_flag))
        else $error("digit shift changed other flags");

    a_err_quiet: assert property (go_err |->                    // RULE11
        !o_wr.en ##1 (!o_wr.en && !o_busy && o_done))
        else $error("bad range touched memory or took long");

    a_dsl_origin: assert property (go_shift && dec_dsl |=>      // RULE12
        s_load_last)
        else $error("left digit shift not begun at end word");

    a_dsr_origin: assert property (go_shift && dec_dsr |=>      // RULE12
        s_load_first)
        else $error("right digit shift not begun at start word");

    a_walk_step: assert property (in_shift && !at_end |=>       // RULE12
        in_shift && o_busy && o_wr.en &&
        ptr_q == (left_q ? $past(ptr_q) - 16'h0001
                         : $past(ptr_q) + 16'h0001))
        else $error("digit shift walk not one word per clock");

    a_walk_end: assert property (in_shift && at_end |=>         // RULE12
        is_idle && o_done && !o_wr.en)
        else $error("digit shift did not stop after last word");

    a_irq_level: assert property (finish |=>
        stat_q[rdsu_pkg::IRQ_DONE] && (o_irq == mask_q[rdsu_pkg::IRQ_DONE]
        || stat_q[rdsu_pkg::IRQ_ERR]))
        else $error("done event not recorded");

endmodule

/* File: tb/rdsu_mem.sv */
// word memory model on the far side of the unit
// assumes one clock shared with the unit; the bench may preload mem
`timescale 1ns/1ps

module rdsu_mem
(
    input  wire logic                        i_clk,
    input  wire logic [rdsu_pkg::ADDR_W-1:0] i_rd_addr,
    output logic [rdsu_pkg::WORD_W-1:0]      o_rd_data,
    input  wire rdsu_pkg::rdsu_wr_t          i_wr
);
    logic [rdsu_pkg::WORD_W-1:0] mem [256];

    // same-cycle read, separate write port
    assign o_rd_data = mem[i_rd_addr[7:0]];

    always @(posedge i_clk)
    begin
        if (i_wr.en)
            mem[i_wr.addr[7:0]] <= i_wr.data;
    end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the rotate and digit shift unit
// assumes rdsu_pkg, rdsu_unit and the rdsu_mem model are compiled first
`timescale 1ns/1ps

module testbench;
    typedef struct {rdsu_pkg::rdsu_flags_t f; int lo; int hi;} rdsu_note_t;
    logic                  clk = 0, rst_b = 0, start = 0, hsel = 0;
    logic                  hwrite = 0, c;
    logic [11:0]           func = 12'h000;
    logic [15:0]           af = 16'h0000, al = 16'h0000, rd_addr, rd_data;
    logic [1:0]            htrans = 2'h0, xs;
    logic [31:0]           haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic                  busy, done, irq, hready, hresp;
    rdsu_pkg::rdsu_wr_t    wr;
    rdsu_pkg::rdsu_flags_t flags, ef;
    logic [15:0]           xm [256];
    rdsu_note_t            notes[$], nt;
    int                    err_total = 0, check_count = 0;
    int                    rs[4] = '{40, 41, 50, 61}, re[4] = '{40, 43, 57, 60};

    rdsu_unit rdsu_unit_inst
    (
        .i_clk(clk), .i_rst_b(rst_b), .i_start(start), .i_func(func),
        .i_addr_first(af), .i_addr_last(al), .o_busy(busy), .o_done(done),
        .o_rd_addr(rd_addr), .i_rd_data(rd_data), .o_wr(wr), .o_flags(flags),
        .o_irq(irq), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hready(hready),
        .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hready),
        .o_hresp(hresp)
    );
    rdsu_mem rdsu_mem_inst
    (
        .i_clk(clk), .i_rd_addr(rd_addr), .o_rd_data(rd_data), .i_wr(wr)
    );

    always #10 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        check(hresp, 1'b0);
    endtask

    task automatic irq_is(input logic e);
        @(negedge clk);
        check(irq, e);
        @(posedge clk);
    endtask

    task automatic issue(input logic [11:0] fc, input int s, input int e,
                         input int nb);
        int n, k;
        start <= 1;
        func <= fc;
        af <= s[15:0];
        al <= e[15:0];
        @(posedge clk);
        start <= 0;
        n = 0;
        k = 0;
        do
        begin
            @(negedge clk);
            n += (busy === 1'b1);
            k++;
        end while (done !== 1'b1 && k < 40);
        check(done, 1'b1);
        check(n, nb);
        @(posedge clk);
    endtask

    task automatic rot(input int a);
        logic [15:0] w, r;
        w = xm[a];
        r = {ef.carry_flag, w[15:1]};
        xm[a] = r;
        ef = {1'b0, r == 16'h0, w[0], r[15]};
        xs[0] = 1;
        notes.push_back('{ef, a, a});
        issue(rdsu_pkg::FUNC_ROT, a, a, 1);
    endtask

    task automatic dig(input logic [11:0] fc, input int s, input int e);
        logic [15:0] t [256];
        t = xm;
        ef.error_flag = s > e;
        xs |= {s > e, 1'b1};
        for (int i = s; i <= e; i++)
            xm[i] = fc == rdsu_pkg::FUNC_DSL ?
                {t[i][11:0], i == s ? 4'h0 : t[i-1][15:12]} :
                {i == e ? 4'h0 : t[i+1][3:0], t[i][15:4]};
        notes.push_back('{ef, s < e ? s : e, s < e ? e : s});
        issue(fc, s, e, s > e ? 0 : e - s + 2);
    endtask

    always @(negedge clk)
    begin
        if (done === 1'b1)
        begin
            if (notes.size() == 0)
                check(1, 0);
            else
            begin
                nt = notes.pop_front();
                check(flags, nt.f);
                for (int i = nt.lo - 1; i <= nt.hi + 1; i++)
                    check(rdsu_mem_inst.mem[i], xm[i]);
            end
        end
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end

    initial
    begin
        void'($urandom(32'h5117));
        for (int i = 0; i < 256; i++)
        begin
            xm[i] = $urandom;
            rdsu_mem_inst.mem[i] = xm[i];
        end
        ef = '0;
        xs = 2'h0;
        repeat (5) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        irq_is(0);
        bus(0, rdsu_pkg::OFF_FLAGS, 32'h0);
        check(rd, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 10; i++)
        begin
            c = i < 2 ? i == 1 : $urandom;
            if (i < 2)
                xm[10+i] = i == 0 ? 16'h0001 : 16'h0000;
            rdsu_mem_inst.mem[10+i] = xm[10+i];
            if (i < 4)
            begin
                bus(1, rdsu_pkg::OFF_FLAGS, {30'h0, c, 1'b0});
                ef.carry_flag = c;
            end
            rot(10 + i);
        end
        bus(0, rdsu_pkg::OFF_FLAGS, 32'h0);
        check(rd, {28'h0, ef});
        $display("test rotate done");
        // ranges kept inside one memory area
        for (int j = 0; j < 8; j++)
            dig(j[0] ? rdsu_pkg::FUNC_DSR : rdsu_pkg::FUNC_DSL,
                rs[j/2], re[j/2]);
        start <= 1;
        func <= 12'h027;
        @(posedge clk);
        start <= 0;
        repeat (3) @(negedge clk);
        check(busy, 0);
        @(posedge clk);
        $display("test digit shift done");
        irq_is(0);
        bus(0, rdsu_pkg::OFF_IRQ_STAT, 32'h0);
        check(rd, {30'h0, xs});
        bus(1, rdsu_pkg::OFF_IRQ_MASK, 32'h2);
        irq_is(1);
        bus(1, rdsu_pkg::OFF_IRQ_STAT, 32'h2);
        irq_is(0);
        bus(0, rdsu_pkg::OFF_IRQ_STAT, 32'h0);
        check(rd, 32'h1);
        bus(1, rdsu_pkg::OFF_IRQ_MASK, 32'h3);
        irq_is(1);
        bus(1, rdsu_pkg::OFF_IRQ_STAT, 32'h3);
        irq_is(0);
        bus(0, 8'h0c, 32'h0);
        check(rd, 32'h0);
        bus(0, rdsu_pkg::OFF_IRQ_MASK, 32'h0);
        check(rd, 32'h3);
        $display("test interrupt done");
        check(notes.size(), 0);
        complete_run();
    end
endmodule
